/* File: rtl/aiac_defs.vh */
`ifndef AIAC_DEFS_VH
`define AIAC_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AIAC_A_CTRL 8'h00
`define AIAC_A_CONF 8'h04
`define AIAC_A_INTV 8'h08
`define AIAC_A_CNT 8'h0C
`define AIAC_A_STAT 8'h10
`define AIAC_A_EVT 8'h14
`define AIAC_A_MASK 8'h18
`define AIAC_A_DATA 8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define AIAC_CTRL_START 0
`define AIAC_CTRL_STOP 1
`define AIAC_CTRL_CLEAR 2
`define AIAC_CONF_START_EXT 0
`define AIAC_CONF_STOP_LO 1
`define AIAC_CONF_STOP_HI 2
`define AIAC_CONF_CLK_EXT 3
`define AIAC_CONF_START_FALL 4
`define AIAC_CONF_STOP_FALL 5
`define AIAC_CONF_CLK_FALL 6
`define AIAC_CONF_FILT 7
`define AIAC_CONF_LAST_LO 8
`define AIAC_CONF_LAST_HI 11
`define AIAC_EVT_END 0
`define AIAC_EVT_OVR 1
`define AIAC_EVT_START 2

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define AIAC_STOP_COUNT 2'h0
`define AIAC_STOP_EXT 2'h1
`define AIAC_STOP_SW 2'h2
`define AIAC_CONF_RST 12'h000
`define AIAC_INTV_RST 24'h0000C8
`define AIAC_CNT_RST 24'h000000
`define AIAC_MASK_RST 3'h0

// ----------------------------------------
// timing and sizes
// ----------------------------------------
`define AIAC_CLK_NS 50
`define AIAC_FILT_NS 1000
`define AIAC_FILT_CYC ((`AIAC_FILT_NS + `AIAC_CLK_NS - 1) / `AIAC_CLK_NS)
`define AIAC_WORD_W 20
`define AIAC_BUF_AW 10
`define AIAC_BUF_DEPTH 1024
`define AIAC_FIFO_AW 4
`define AIAC_FIFO_DEPTH 16

`endif

/* File: rtl/aiac_fifo.v */
// ----------------------------------------
// small elastic fifo between converter and buffer
// ----------------------------------------
module aiac_fifo #(
  parameter W = 20,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset, only pointers and count do
  always @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  // pointers wrap naturally because depth is a power of two
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= wp_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_reg <= rp_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* File: rtl/aiac_mem.v */
// ----------------------------------------
// sample buffer memory, registered read
// ----------------------------------------
module aiac_mem #(
  parameter W = 20,
  parameter AW = 10
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  // write-first bypass so a word written now is readable next cycle
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* File: rtl/aiac_top.v */
`include "aiac_defs.vh"

module aiac_top (
  input wire clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire ext_start,
  input wire ext_stop,
  input wire ext_clk,
  input wire adc_done,
  input wire [15:0] adc_data,
  output reg adc_start,
  output reg [3:0] adc_ch,
  output reg irq_n
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ARMED = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_ISSUE = 3'h3;
  localparam ST_CONV = 3'h4;
  localparam [31:0] FILT_LAST_W = `AIAC_FILT_CYC - 1;
  localparam [4:0] FILT_LAST = FILT_LAST_W[4:0];

  // edge of the chosen polarity between two samples of a level
  function edge_hit;
    input prev;
    input cur;
    input fall;
    begin
      edge_hit = fall ? (prev & ~cur) : (~prev & cur);
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [11:0] conf_reg;
  reg [23:0] intv_reg;
  reg [23:0] cnt_reg;
  reg [2:0] mask_reg;
  reg [2:0] evt_reg;
  reg [2:0] evt_next;
  reg [2:0] st_reg;
  reg [2:0] st_next;
  reg [23:0] tmr_reg;
  reg [23:0] done_cnt_reg;
  reg [3:0] s1_reg;
  reg [3:0] s2_reg;
  reg [3:0] s3_reg;
  reg [3:0] lvl_reg;
  reg [3:0] prev_reg;
  reg [1:0] filt_reg;
  reg [4:0] fcnt0_reg;
  reg [4:0] fcnt1_reg;
  reg [9:0] wptr_reg;
  reg [9:0] rptr_reg;
  reg [10:0] level_reg;
  reg [31:0] rdata_next;

  wire start_ext = conf_reg[`AIAC_CONF_START_EXT];
  wire [1:0] stop_src = conf_reg[`AIAC_CONF_STOP_HI:`AIAC_CONF_STOP_LO];
  wire clk_ext = conf_reg[`AIAC_CONF_CLK_EXT];
  wire filt_en = conf_reg[`AIAC_CONF_FILT];
  wire [3:0] last_ch = conf_reg[`AIAC_CONF_LAST_HI:`AIAC_CONF_LAST_LO];
  wire wr_ctrl = wr && (addr == `AIAC_A_CTRL);
  wire sw_start = wr_ctrl && wdata[`AIAC_CTRL_START];
  wire sw_stop = wr_ctrl && wdata[`AIAC_CTRL_STOP];
  wire buf_clear = wr_ctrl && wdata[`AIAC_CTRL_CLEAR];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // three stages; a level only moves once stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
      lvl_reg <= 4'h0;
    end else begin
      s1_reg <= {adc_done, ext_clk, ext_stop, ext_start};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
    end
  end

  // chatter filter
  // a new level must hold for the full filter time before it is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= 2'h0;
      fcnt0_reg <= 5'h00;
      fcnt1_reg <= 5'h00;
    end else begin
      if (!filt_en || lvl_reg[0] == filt_reg[0]) begin
        filt_reg[0] <= lvl_reg[0];
        fcnt0_reg <= 5'h00;
      end else if (fcnt0_reg == FILT_LAST) begin
        filt_reg[0] <= lvl_reg[0];
        fcnt0_reg <= 5'h00;
      end else begin
        fcnt0_reg <= fcnt0_reg + 5'h01;
      end
      if (!filt_en || lvl_reg[1] == filt_reg[1]) begin
        filt_reg[1] <= lvl_reg[1];
        fcnt1_reg <= 5'h00;
      end else if (fcnt1_reg == FILT_LAST) begin
        filt_reg[1] <= lvl_reg[1];
        fcnt1_reg <= 5'h00;
      end else begin
        fcnt1_reg <= fcnt1_reg + 5'h01;
      end
    end
  end

  wire [3:0] cur_lvl = {lvl_reg[3:2], filt_reg};

  // previous samples for edge detection
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 4'h0;
    end else begin
      prev_reg <= cur_lvl;
    end
  end

  wire start_edge = edge_hit(prev_reg[0], cur_lvl[0], conf_reg[`AIAC_CONF_START_FALL]);
  wire stop_edge = edge_hit(prev_reg[1], cur_lvl[1], conf_reg[`AIAC_CONF_STOP_FALL]);
  wire clk_edge = edge_hit(prev_reg[2], cur_lvl[2], conf_reg[`AIAC_CONF_CLK_FALL]);
  wire done_rise = edge_hit(prev_reg[3], cur_lvl[3], 1'b0);

  // ----------------------------------------
  // pacing and sequencing
  // ----------------------------------------
  wire running = (st_reg == ST_WAIT) || (st_reg == ST_ISSUE) || (st_reg == ST_CONV);
  wire tmr_tick = ({1'b0, tmr_reg} + 25'h0000001) >= {1'b0, intv_reg};
  wire pace = clk_ext ? clk_edge : tmr_tick;
  wire ext_halt = (stop_src == `AIAC_STOP_EXT) && stop_edge;
  wire halt = running && (sw_stop || ext_halt);
  wire fifo_in_ready;
  wire push = (st_reg == ST_CONV) && done_rise;
  wire scan_end = push && (adc_ch == last_ch);
  wire count_hit = (stop_src == `AIAC_STOP_COUNT) && (cnt_reg != 24'h000000)
                   && ((done_cnt_reg + 24'h000001) == cnt_reg);
  wire go = (st_reg == ST_IDLE && sw_start && !start_ext)
            || (st_reg == ST_ARMED && start_edge);

  // interval timer restarts at each tick and at start
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg <= 24'h000000;
    end else if (!running || tmr_tick) begin
      tmr_reg <= 24'h000000;
    end else begin
      tmr_reg <= tmr_reg + 24'h000001;
    end
  end

  // next state; a stop wins over everything else while running, a software stop also while armed
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (sw_start) begin
          st_next = start_ext ? ST_ARMED : (clk_ext ? ST_WAIT : ST_ISSUE);
        end
      end
      ST_ARMED: begin
        if (sw_stop) begin
          st_next = ST_IDLE;
        end else if (start_edge) begin
          st_next = clk_ext ? ST_WAIT : ST_ISSUE;
        end
      end
      ST_WAIT: begin
        if (pace) begin
          st_next = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // back-pressure: hold off the converter while the fifo is full
        if (fifo_in_ready) begin
          st_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (scan_end) begin
          st_next = count_hit ? ST_IDLE : ST_WAIT;
        end else if (push) begin
          st_next = ST_ISSUE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
    if (halt) begin
      st_next = ST_IDLE;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      adc_start <= 1'b0;
      adc_ch <= 4'h0;
      done_cnt_reg <= 24'h000000;
    end else begin
      st_reg <= st_next;
      adc_start <= (st_reg == ST_ISSUE) && fifo_in_ready && !halt;
      if (go) begin
        adc_ch <= 4'h0;
        done_cnt_reg <= 24'h000000;
      end else if (scan_end) begin
        adc_ch <= 4'h0;
        done_cnt_reg <= done_cnt_reg + 24'h000001;
      end else if (push) begin
        adc_ch <= adc_ch + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // data path: fifo then 1k buffer
  // ----------------------------------------
  wire fifo_out_valid;
  wire [19:0] fifo_out_data;
  wire [19:0] mem_q;
  wire buf_full = (level_reg == `AIAC_BUF_DEPTH);
  wire mem_we = fifo_out_valid && !buf_full && !buf_clear;
  wire pop = rd && (addr == `AIAC_A_DATA) && (level_reg != 11'h000);
  wire [9:0] rptr_next = buf_clear ? 10'h000 : (pop ? rptr_reg + 10'h001 : rptr_reg);

  aiac_fifo #(
    .W(`AIAC_WORD_W),
    .D(`AIAC_FIFO_DEPTH),
    .AW(`AIAC_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(buf_clear),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({adc_ch, adc_data}),
    .out_valid(fifo_out_valid),
    .out_ready(!buf_full),
    .out_data(fifo_out_data)
  );

  aiac_mem #(
    .W(`AIAC_WORD_W),
    .AW(`AIAC_BUF_AW)
  ) u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(wptr_reg),
    .wdata(fifo_out_data),
    .raddr(rptr_next),
    .rdata(mem_q)
  );

  // buffer pointers; fill stalls while the buffer is full until the host reads
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= 10'h000;
      rptr_reg <= 10'h000;
      level_reg <= 11'h000;
    end else if (buf_clear) begin
      wptr_reg <= 10'h000;
      rptr_reg <= 10'h000;
      level_reg <= 11'h000;
    end else begin
      rptr_reg <= rptr_next;
      if (mem_we) begin
        wptr_reg <= wptr_reg + 10'h001;
      end
      if (mem_we && !pop) begin
        level_reg <= level_reg + 11'h001;
      end else if (pop && !mem_we) begin
        level_reg <= level_reg - 11'h001;
      end
    end
  end

  // ----------------------------------------
  // software registers and interrupt
  // ----------------------------------------
  // sticky events; a set in the same cycle as its clear wins
  always @* begin
    evt_next = evt_reg;
    if (wr && addr == `AIAC_A_EVT) begin
      evt_next = evt_reg & ~wdata[2:0];
    end
    evt_next[`AIAC_EVT_END] = evt_next[`AIAC_EVT_END] | (running && st_next == ST_IDLE);
    evt_next[`AIAC_EVT_OVR] = evt_next[`AIAC_EVT_OVR]
                              | (pace && (st_reg == ST_ISSUE || st_reg == ST_CONV));
    evt_next[`AIAC_EVT_START] = evt_next[`AIAC_EVT_START] | go;
  end

  // read mux; unmapped offsets read zero
  always @* begin
    rdata_next = 32'h00000000;
    case (addr)
      `AIAC_A_CONF: rdata_next = {20'h00000, conf_reg};
      `AIAC_A_INTV: rdata_next = {8'h00, intv_reg};
      `AIAC_A_CNT: rdata_next = {8'h00, cnt_reg};
      `AIAC_A_STAT: rdata_next = {12'h000, level_reg, 3'h0, st_reg, 1'b0,
                                   buf_full, level_reg == 11'h000};
      `AIAC_A_EVT: rdata_next = {29'h00000000, evt_reg};
      `AIAC_A_MASK: rdata_next = {29'h00000000, mask_reg};
      `AIAC_A_DATA: rdata_next = (level_reg != 11'h000) ? {12'h000, mem_q} : 32'h00000000;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // config registers are written in any state; writes always land
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conf_reg <= `AIAC_CONF_RST;
      intv_reg <= `AIAC_INTV_RST;
      cnt_reg <= `AIAC_CNT_RST;
      mask_reg <= `AIAC_MASK_RST;
      evt_reg <= 3'h0;
      rdata <= 32'h00000000;
      irq_n <= 1'b1;
    end else begin
      if (wr && addr == `AIAC_A_CONF) begin
        conf_reg <= wdata[11:0];
      end
      if (wr && addr == `AIAC_A_INTV) begin
        intv_reg <= wdata[23:0];
      end
      if (wr && addr == `AIAC_A_CNT) begin
        cnt_reg <= wdata[23:0];
      end
      if (wr && addr == `AIAC_A_MASK) begin
        mask_reg <= wdata[2:0];
      end
      evt_reg <= evt_next;
      if (rd) begin
        rdata <= rdata_next;
      end else begin
        rdata <= 32'h00000000;
      end
      irq_n <= ~|(evt_next & mask_reg);
    end
  end
endmodule

/* File: test/aiac_adc_model.sv */
// ----------------------------------------
// converter model: answers each start after a short or long delay
// ----------------------------------------
module aiac_adc_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adc_start,
  input wire logic [3:0] adc_ch,
  input wire logic [15:0] salt,
  input wire logic slow,
  output logic adc_done,
  output logic [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  logic [4:0] wait_cnt;
  logic [2:0] hold_cnt;
  logic [15:0] res;

  // result held while done is high; inverted after so stale data never match
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 16'hFFFF;
      wait_cnt <= 5'h00;
      hold_cnt <= 3'h0;
    end else if (adc_start) begin
      busy <= 1'b1;
      adc_done <= 1'b0;
      wait_cnt <= slow ? 5'h0C : 5'h02;
      res <= salt ^ {4{adc_ch}};
    end else if (busy && wait_cnt != 5'h00) begin
      wait_cnt <= wait_cnt - 5'h01;
    end else if (busy && !adc_done) begin
      adc_done <= 1'b1;
      adc_data <= res;
      hold_cnt <= 3'h7;
    end else if (adc_done && hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else if (adc_done) begin
      adc_done <= 1'b0;
      busy <= 1'b0;
      adc_data <= ~adc_data;
    end
  end
endmodule

/* File: test/aiac_sva.sv */
`include "aiac_defs.vh"

// ----------------------------------------
// port checker for the acquisition control
// ----------------------------------------
module aiac_sva (
  input wire clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire ext_start,
  input wire ext_stop,
  input wire ext_clk,
  input wire adc_done,
  input wire [15:0] adc_data,
  input wire adc_start,
  input wire [3:0] adc_ch,
  input wire irq_n
);
  logic [11:0] conf_q;
  logic [4:0] since_clk;
  logic clk_pin_q;

  // shadow of the config and an age counter for the sampling clock pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conf_q <= 12'h000;
      since_clk <= 5'h1F;
      clk_pin_q <= 1'b0;
    end else begin
      clk_pin_q <= ext_clk;
      if (wr && addr == `AIAC_A_CONF)
        conf_q <= wdata[11:0];
      if (ext_clk && !clk_pin_q)
        since_clk <= 5'h00;
      else if (since_clk != 5'h1F)
        since_clk <= since_clk + 5'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  start_pulse_a: assert property (adc_start |=> !adc_start [*4])
    else $error("conversion start not a lone pulse");
  stop_quiet_a: assert property (wr && addr == `AIAC_A_CTRL && wdata[1:0] == 2'h2
    |=> !adc_start [*8]) else $error("conversion issued after stop");
  ch_range_a: assert property (adc_start |-> adc_ch <= conf_q[11:8])
    else $error("channel beyond last channel");
  ch_hold_a: assert property (adc_start |=> (wr || $stable(adc_ch)) [*3])
    else $error("channel moved during conversion");
  mask_off_a: assert property (wr && addr == `AIAC_A_MASK && wdata[2:0] == 3'h0
    |-> ##2 irq_n) else $error("interrupt stays with all masked");
  read_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside answer cycle");
  sw_start_a: assert property (wr && addr == `AIAC_A_CTRL && wdata[2:0] == 3'h1
    && !conf_q[0] && !conf_q[3] |-> ##[1:4] adc_start) else $error("software start ignored");
  clk_pace_a: assert property (adc_start && conf_q[3] && !conf_q[6] && adc_ch == 4'h0
    |-> since_clk < 5'd16) else $error("conversion without sampling clock edge");

  cover property (adc_start && adc_ch == 4'h3);
  cover property ($fell(irq_n));
  cover property (wr && addr == `AIAC_A_CTRL && wdata[1]);
endmodule

/* File: test/tb_aiac_top.sv */
`include "aiac_defs.vh"

module tb_aiac_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd, ext_start, ext_stop, ext_clk, slow, rd_q;
  logic [7:0] addr;
  logic [31:0] wdata, rd_last, seed;
  logic [15:0] salt;
  wire [31:0] rdata;
  wire adc_done, adc_start, irq_n;
  wire [15:0] adc_data;
  wire [3:0] adc_ch;
  int num_errors, compares, cycles;
  logic [31:0] q_exp[$], q_msk[$];
  string q_name[$];

  aiac_top u_aiac_top (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ext_start, .ext_stop,
    .ext_clk, .adc_done, .adc_data, .adc_start, .adc_ch, .irq_n);
  aiac_adc_model u_aiac_adc_model (.clk, .rst_n, .adc_start, .adc_ch, .salt, .slow, .adc_done,
    .adc_data);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  // ----------------------------------------
  // bus tasks, entered just after a rising edge
  // ----------------------------------------
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // a zero mask notes a read whose value only the driver uses
  task rd_reg(input logic [7:0] a, input string n, input logic [31:0] e, input logic [31:0] m);
    q_name.push_back(n);
    q_exp.push_back(e);
    q_msk.push_back(m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    rd_last = rdata;
  endtask

  task irq_chk(input logic e);
    @(posedge clk);
    chk("irq_n", {31'h0, e}, {31'h0, irq_n});
  endtask

  task wait_idle;
    for (int i = 0; i < 300; i++) begin
      rd_reg(`AIAC_A_STAT, "stat", 32'h0, 32'h0);
      if (rd_last[5:3] === 3'h0)
        break;
    end
  endtask

  // words come out channel 0..last per scan
  task drain(input int n, input logic [3:0] last_ch);
    logic [3:0] ch;
    for (int k = 0; k < n; k++) begin
      ch = 4'(k % (last_ch + 1));
      rd_reg(`AIAC_A_DATA, "word", {12'h0, ch, salt ^ {4{ch}}}, 32'hFFFFFFFF);
    end
  endtask

  // answer watcher: oldest note against the data after each read
  always @(posedge clk) begin
    rd_q <= rd;
    cycles++;
    if (rd_q === 1'b1) begin
      if (q_msk[0] != 32'h0)
        chk(q_name[0], q_exp[0], rdata & q_msk[0]);
      q_name.delete(0);
      q_exp.delete(0);
      q_msk.delete(0);
    end
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end

  initial begin
    rst_n = 1'b0;
    {wr, rd, ext_start, ext_stop, ext_clk, slow} = 6'h00;
    addr = 8'h00;
    wdata = 32'h0;
    salt = 16'h0;
    seed = 32'h0fb9ceb1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // ----------------------------------------
    // reset values, unmapped place
    // ----------------------------------------
    rd_reg(`AIAC_A_CONF, "conf", 32'h0, 32'hFFF);
    rd_reg(`AIAC_A_INTV, "intv", 32'hC8, 32'hFFFFFF);
    rd_reg(`AIAC_A_CNT, "cnt", 32'h0, 32'hFFFFFF);
    rd_reg(`AIAC_A_MASK, "mask", 32'h0, 32'h7);
    rd_reg(`AIAC_A_STAT, "stat", 32'h1, 32'hFFE3B);
    rd_reg(`AIAC_A_CTRL, "ctrl", 32'h0, 32'hFFFFFFFF);
    rd_reg(8'h20, "unmapped", 32'h0, 32'hFFFFFFFF);
    irq_chk(1'b1);
    // ----------------------------------------
    // timer pace, four channels, stop after two scans
    // ----------------------------------------
    seed = xs(seed);
    salt <= seed[15:0];
    wr_reg(`AIAC_A_CONF, 32'h300);
    wr_reg(`AIAC_A_INTV, 32'd150);
    wr_reg(`AIAC_A_CNT, 32'd2);
    wr_reg(`AIAC_A_CTRL, 32'h1);
    wait_idle;
    repeat (10) @(posedge clk);
    rd_reg(`AIAC_A_STAT, "level", 32'h1000, 32'hFFE3B);
    rd_reg(`AIAC_A_EVT, "events", 32'h5, 32'h7);
    wr_reg(`AIAC_A_MASK, 32'h2);
    irq_chk(1'b1);
    wr_reg(`AIAC_A_MASK, 32'h1);
    irq_chk(1'b0);
    wr_reg(`AIAC_A_EVT, 32'h7);
    irq_chk(1'b1);
    wr_reg(`AIAC_A_MASK, 32'h0);
    drain(8, 4'h3);
    rd_reg(`AIAC_A_DATA, "empty", 32'h0, 32'hFFFFFFFF);
    // ----------------------------------------
    // falling start pin filtered, sampling clock pin, stop pin
    // ----------------------------------------
    ext_start <= 1'b1;
    seed = xs(seed);
    salt <= seed[15:0];
    wr_reg(`AIAC_A_CONF, 32'h9B);
    wr_reg(`AIAC_A_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    rd_reg(`AIAC_A_STAT, "armed", 32'h8, 32'h38);
    ext_start <= 1'b0;
    repeat (10) @(posedge clk);
    ext_start <= 1'b1;
    repeat (40) @(posedge clk);
    rd_reg(`AIAC_A_STAT, "start glitch", 32'h8, 32'h38);
    ext_start <= 1'b0;
    repeat (40) @(posedge clk);
    rd_reg(`AIAC_A_STAT, "started", 32'h10, 32'h38);
    ext_stop <= 1'b1;
    repeat (10) @(posedge clk);
    ext_stop <= 1'b0;
    repeat (40) @(posedge clk);
    rd_reg(`AIAC_A_STAT, "stop glitch", 32'h10, 32'h38);
    repeat (3) begin
      ext_clk <= 1'b1;
      repeat (5) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (30) @(posedge clk);
    end
    ext_stop <= 1'b1;
    repeat (40) @(posedge clk);
    ext_stop <= 1'b0;
    rd_reg(`AIAC_A_STAT, "stopped", 32'h0, 32'h38);
    rd_reg(`AIAC_A_EVT, "events", 32'h5, 32'h7);
    drain(3, 4'h0);
    // ----------------------------------------
    // overrun with a slow converter, software stop, clear
    // ----------------------------------------
    slow <= 1'b1;
    wr_reg(`AIAC_A_EVT, 32'h7);
    wr_reg(`AIAC_A_INTV, 32'h1);
    wr_reg(`AIAC_A_CONF, 32'h104);
    wr_reg(`AIAC_A_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    wr_reg(`AIAC_A_CTRL, 32'h2);
    rd_reg(`AIAC_A_STAT, "halted", 32'h0, 32'h38);
    rd_reg(`AIAC_A_EVT, "overrun", 32'h7, 32'h7);
    wr_reg(`AIAC_A_CTRL, 32'h4);
    rd_reg(`AIAC_A_STAT, "cleared", 32'h1, 32'hFFE3B);
    tally_and_finish;
  end
endmodule

bind aiac_top aiac_sva u_aiac_sva (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ext_start,
  .ext_stop, .ext_clk, .adc_done, .adc_data, .adc_start, .adc_ch, .irq_n);
